// >>> hdl/flash_programming_select_pin_port.sv
// Serial flash programming port: four-byte instructions from an external programmer.
// Assumes the flash macro (page buffer, array, erase timing) sits on the fl_* and rd_* ports
// in the clk_i domain; sck, si and the select pin are asynchronous pins.
`timescale 1ns/1ps
`include "flash_programming_select_pin_cfg.svh"
module flash_programming_select_pin_port
#(
  parameter int          FIFO_DEPTH = 16,
  parameter logic [47:0] SIG_BYTES  = 48'h0102_0304_0506  // Arbitrary identity value
) (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  sck_i,
  input  wire logic                  si_i,
  input  wire logic                  programming_select_pin_n_i,
  output logic                       so_o,
  output logic                       so_oe_o,
  output logic                       armed_o,
  output logic [`FP_TIMING_W-1:0]    flash_timing_value_o,
  output logic [7:0]                 lock_bits_o,
  output logic                       overrun_o,
  output logic                       fl_cmd_valid_o,
  output flash_programming_select_pin_pkg::fl_cmd_t    fl_cmd_o,
  input  wire logic                  fl_cmd_ready_i,
  input  wire logic                  fl_busy_i,
  output logic                       rd_req_o,
  output flash_programming_select_pin_pkg::fl_addr_t   rd_addr_o,
  input  wire logic [7:0]            rd_data_i,
  input  wire logic                  rd_valid_i
);
  import flash_programming_select_pin_pkg::*;

  if (FIFO_DEPTH < 2)
  begin : g_bad_depth
    $error("flash_programming_select_pin_port: FIFO_DEPTH must be at least 2");
  end

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic       sck_s1_q, sck_s2_q, sck_prev_q;
  logic       si_s1_q, si_s2_q;
  logic       sel_s1_q, sel_s2_q;
  logic       sck_rise, sck_fall, sel_active;

  // Two flops per pin before any logic looks at it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      {sck_s1_q, sck_s2_q, sck_prev_q, si_s1_q, si_s2_q} <= 5'h00;
      {sel_s1_q, sel_s2_q}                               <= 2'h3;  // Idle level: deselected
    end
    else
    begin
      {sck_s1_q, sck_s2_q, sck_prev_q} <= {sck_i, sck_s1_q, sck_s2_q};
      {si_s1_q, si_s2_q}               <= {si_i, si_s1_q};
      {sel_s1_q, sel_s2_q}             <= {programming_select_pin_n_i, sel_s1_q};
    end
  end
  assign sel_active = ~sel_s2_q;
  assign sck_rise   = sel_active & sck_s2_q & ~sck_prev_q;
  assign sck_fall   = sel_active & ~sck_s2_q & sck_prev_q;

  // ------------------------------------------------------------
  // Receive shifter and bit counter
  // ------------------------------------------------------------
  logic [31:0] rx_q;
  logic [31:0] rx_next;
  logic [4:0]  bit_cnt_q;
  logic        armed_q;
  logic        sync_hit;
  logic        frame_end;
  logic        byte3_end;
  cmd_t        cmd_now;
  assign rx_next   = {rx_q[30:0], si_s2_q};
  assign sync_hit  = (rx_next[15:0] == {`FP_OP_PREFIX, `FP_OP_ENABLE_B2});
  assign frame_end = sck_rise & (bit_cnt_q == 5'd31);
  assign byte3_end = sck_rise & (bit_cnt_q == 5'd23);
  assign cmd_now   = frame_end ? decode_cmd(rx_next[31:24], rx_next[23:16])
                               : decode_cmd(rx_next[23:16], rx_next[15:8]);
  // Shift on every rising edge; unarmed, hunt for the enable pattern
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !sel_active)
    begin
      rx_q      <= '0;
      bit_cnt_q <= '0;
    end
    else if (sck_rise)
    begin
      rx_q <= rx_next;
      if (!armed_q && sync_hit)
        bit_cnt_q <= 5'd16;
      else
        bit_cnt_q <= bit_cnt_q + 5'd1;
    end
  end

  // Armed after a complete enable instruction, dropped with the select pin
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !sel_active)
      armed_q <= 1'b0;
    else if (frame_end && cmd_now == CMD_ENABLE)
      armed_q <= 1'b1;
  end

  // ------------------------------------------------------------
  // Transmit byte selection and shifting
  // ------------------------------------------------------------
  logic [7:0] echo_q;
  logic [7:0] resp_q;
  logic [7:0] tx_q;
  logic       rd_wait_q;
  logic       write_busy;
  logic       fifo_out_valid;
  logic [7:0] load_byte;
  assign write_busy = fl_busy_i | fl_cmd_valid_o | fifo_out_valid;
  assign load_byte  = (bit_cnt_q[4:3] == 2'd2)            ? echo_q :
                      (bit_cnt_q[4:3] == 2'd3 && armed_q) ? resp_q : 8'h00;

  // Echo byte decided once byte two is in
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !sel_active)
      echo_q <= '0;
    else if (sck_rise && (sync_hit && (!armed_q || bit_cnt_q == 5'd15)))
      echo_q <= `FP_OP_ENABLE_B2;
    else if (sck_rise && bit_cnt_q == 5'd15)
      echo_q <= '0;
  end

  // Byte four answer for read-type instructions
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      resp_q    <= '0;
      rd_wait_q <= 1'b0;
      rd_req_o  <= 1'b0;
      rd_addr_o <= '0;
    end
    else
    begin
      rd_req_o <= 1'b0;
      if (byte3_end && armed_q)
      begin
        resp_q    <= '0;
        rd_wait_q <= 1'b0;
        unique case (cmd_now)
          CMD_READ:
          begin
            if (write_busy)
              resp_q <= `FP_READ_BUSY;
            else if (!lock_bits_o[`FP_LOCK_SPIRE])
              resp_q <= `FP_READ_LOCKED;
            else
            begin
              rd_req_o  <= 1'b1;
              rd_wait_q <= 1'b1;
              rd_addr_o <= '{page: rx_next[15:8],
                             offset: {rx_next[7:2], rx_next[16+`FP_OP_HSEL_BIT]}};
            end
          end
          CMD_LOCK_RD:
            resp_q <= lock_bits_o;
          CMD_SIG:
            if (rx_next[2:0] < 3'd6)
              resp_q <= SIG_BYTES[8*(5-rx_next[2:0]) +: 8];
          CMD_NONE, CMD_ENABLE, CMD_TIMING, CMD_ERASE, CMD_LOAD,
          CMD_PROGRAM, CMD_LOCK_WR:
            resp_q <= '0;
        endcase
      end
      else if (rd_wait_q && rd_valid_i)
      begin
        resp_q    <= rd_data_i;
        rd_wait_q <= 1'b0;
      end
    end
  end

  // Serial output: load a byte at each byte boundary, else shift, after sck falls
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !sel_active)
    begin
      tx_q    <= '0;
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
    end
    else
    begin
      so_oe_o <= 1'b1;
      if (sck_fall)
      begin
        if (bit_cnt_q[2:0] == 3'd0)
        begin
          tx_q <= {load_byte[6:0], 1'b0};
          so_o <= load_byte[7];
        end
        else
        begin
          so_o <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Instruction execution at frame end
  // ------------------------------------------------------------
  logic    push_valid;
  logic    push_ready;
  fl_cmd_t push_cmd;
  logic    exec;
  assign exec = frame_end & armed_q;
  // Queue the write-type operations toward the flash macro
  always_comb
  begin
    push_valid = 1'b0;
    push_cmd   = '{op: FL_ERASE, addr: '0, data: rx_next[7:0]};
    if (exec)
    begin
      unique case (cmd_now)
        CMD_ERASE:
          push_valid = 1'b1;
        CMD_LOAD:
        begin
          push_valid = 1'b1;
          push_cmd.op   = FL_LOAD;
          push_cmd.addr = '{page: '0,
                            offset: {rx_next[15:10], rx_next[24+`FP_OP_HSEL_BIT]}};
        end
        CMD_PROGRAM:
        begin
          push_valid = 1'b1;
          push_cmd.op   = FL_PROGRAM;
          push_cmd.addr = '{page: rx_next[23:16], offset: '0};
        end
        CMD_NONE, CMD_ENABLE, CMD_TIMING, CMD_READ, CMD_LOCK_WR,
        CMD_LOCK_RD, CMD_SIG:
          push_valid = 1'b0;
      endcase
    end
  end

  // Timing value and protection bits
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      flash_timing_value_o <= '0;
      lock_bits_o          <= `FP_LOCK_RESET;
    end
    else if (exec)
    begin
      if (cmd_now == CMD_TIMING)
        flash_timing_value_o <= rx_next[`FP_TIMING_W-1:0];
      else if (cmd_now == CMD_ERASE && push_ready)
        lock_bits_o <= `FP_LOCK_RESET;
      else if (cmd_now == CMD_LOCK_WR)
        lock_bits_o <= lock_bits_o & rx_next[7:0];
    end
  end

  // Sticky flag: an operation arrived while the queue was full and was dropped
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !sel_active)
      overrun_o <= 1'b0;
    else if (push_valid && !push_ready)
      overrun_o <= 1'b1;
  end
  assign armed_o = armed_q;

  // ------------------------------------------------------------
  // Operation queue and registered output stage
  // ------------------------------------------------------------
  fl_cmd_t fifo_out;
  logic    fifo_pop;
  assign fifo_pop = fifo_out_valid & (~fl_cmd_valid_o | fl_cmd_ready_i);
  fp_cmd_fifo #(
    .WIDTH (($bits(fl_cmd_t))),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_cmd),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );

  // Hold an operation on the flash port until the macro takes it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      fl_cmd_valid_o <= 1'b0;
      fl_cmd_o       <= '0;
    end
    else if (fifo_pop)
    begin
      fl_cmd_valid_o <= 1'b1;
      fl_cmd_o       <= fifo_out;
    end
    else if (fl_cmd_ready_i)
      fl_cmd_valid_o <= 1'b0;
  end
endmodule : flash_programming_select_pin_port

// >>> hdl/flash_programming_select_pin_cfg.svh
// Constants of the serial flash programming port: opcodes, fields, reset values.
// Assumes inclusion by the package and the port module only.
`ifndef FLASH_PROGRAMMING_SELECT_PIN_CFG_SVH
`define FLASH_PROGRAMMING_SELECT_PIN_CFG_SVH

// ------------------------------------------------------------
// Instruction framing
// ------------------------------------------------------------
`define FP_FRAME_BITS     32
`define FP_SYNC_STAGES    2

// ------------------------------------------------------------
// Opcode patterns, first and second byte
// ------------------------------------------------------------
`define FP_OP_PREFIX      8'hAC
`define FP_OP_ENABLE_B2   8'h53
`define FP_OP_TIMING_B2   8'h5D
`define FP_OP_ERASE_B2HI  3'h4
`define FP_OP_LOCKWR_B2HI 3'h7
`define FP_OP_LOAD        8'h40
`define FP_OP_PROGRAM     8'h4C
`define FP_OP_READ        8'h20
`define FP_OP_LOCKRD      8'h58
`define FP_OP_SIG         8'h30
`define FP_OP_HSEL_MASK   8'hF7
`define FP_OP_HSEL_BIT    3

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define FP_TIMING_W       6
`define FP_LOCK_RESET     8'hFF
`define FP_READ_BUSY      8'hFF
`define FP_READ_LOCKED    8'h00
`define FP_LOCK_SPIRE     0

`endif

// >>> hdl/flash_programming_select_pin_pkg.sv
// Types of the serial flash programming port.
// Assumes flash_programming_select_pin_cfg.svh sits beside it.
package flash_programming_select_pin_pkg;
  `include "flash_programming_select_pin_cfg.svh"

  // Decoded serial instruction
  typedef enum logic [3:0] {
    CMD_NONE, CMD_ENABLE, CMD_TIMING, CMD_ERASE, CMD_LOAD,
    CMD_PROGRAM, CMD_READ, CMD_LOCK_WR, CMD_LOCK_RD, CMD_SIG
  } cmd_t;

  // Operation handed to the flash macro
  typedef enum logic [1:0] {
    FL_ERASE, FL_LOAD, FL_PROGRAM
  } fl_op_t;

  // Flash byte address: page and 7 bit offset within it
  typedef struct packed {
    logic [7:0] page;
    logic [6:0] offset;
  } fl_addr_t;

  // One queued flash operation
  typedef struct packed {
    fl_op_t     op;
    fl_addr_t   addr;
    logic [7:0] data;
  } fl_cmd_t;

  // Opcode decode from the first two bytes
  function automatic cmd_t decode_cmd(input logic [7:0] b1, input logic [7:0] b2);
    cmd_t c;
    c = CMD_NONE;
    if (b1 == `FP_OP_PREFIX)
    begin
      if (b2 == `FP_OP_ENABLE_B2)
        c = CMD_ENABLE;
      else if (b2 == `FP_OP_TIMING_B2)
        c = CMD_TIMING;
      else if (b2[7:5] == `FP_OP_ERASE_B2HI)
        c = CMD_ERASE;
      else if (b2[7:5] == `FP_OP_LOCKWR_B2HI)
        c = CMD_LOCK_WR;
    end
    else if ((b1 & `FP_OP_HSEL_MASK) == `FP_OP_LOAD)
      c = CMD_LOAD;
    else if (b1 == `FP_OP_PROGRAM)
      c = CMD_PROGRAM;
    else if ((b1 & `FP_OP_HSEL_MASK) == `FP_OP_READ)
      c = CMD_READ;
    else if (b1 == `FP_OP_LOCKRD)
      c = CMD_LOCK_RD;
    else if (b1 == `FP_OP_SIG)
      c = CMD_SIG;
    return c;
  endfunction : decode_cmd
endpackage : flash_programming_select_pin_pkg

// >>> hdl/fp_cmd_fifo.sv
// Synchronous FIFO holding queued flash operations.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module fp_cmd_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_size
    $error("fp_cmd_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage, written on push
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_i;
  end

  // Pointers and fill level
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule : fp_cmd_fifo

// >>> tb/programming_select_pin_port_chk.sv
// Assertions on the serial flash programming port, bound to its top module.
// Assumes one clock domain, clk_i, with synchronous reset srst_i.
`timescale 1ns/1ps
module programming_select_pin_port_chk (
  input wire logic                    clk_i,
  input wire logic                    srst_i,
  input wire logic                    sck_i,
  input wire logic                    programming_select_pin_n_i,
  input wire logic                    so_o,
  input wire logic                    so_oe_o,
  input wire logic                    armed_o,
  input wire logic [5:0]              flash_timing_value_o,
  input wire logic [7:0]              lock_bits_o,
  input wire logic                    overrun_o,
  input wire logic                    fl_cmd_valid_o,
  input wire flash_programming_select_pin_pkg::fl_cmd_t fl_cmd_o,
  input wire logic                    fl_cmd_ready_i,
  input wire logic                    rd_req_o
);
  import flash_programming_select_pin_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // Select pin gates the serial side: output enable, arming and overrun
  AST_OE_OFF: assert property (programming_select_pin_n_i [*5] |-> !so_oe_o && !armed_o)
    else $error("port active while deselected");
  AST_OE_ON: assert property ((!programming_select_pin_n_i) [*5] |-> so_oe_o)
    else $error("output not enabled while selected");
  AST_OVR_CLR: assert property (programming_select_pin_n_i [*5] |-> !overrun_o)
    else $error("overrun kept while deselected");
  AST_ARM_SEL: assert property ($rose(armed_o) |-> !$past(programming_select_pin_n_i, 2))
    else $error("armed without select");
  // Nothing but enable acts before arming
  AST_TIM_ARMED: assert property ($changed(flash_timing_value_o) |-> armed_o)
    else $error("timing changed while unarmed");
  AST_OP_ARMED: assert property ($rose(fl_cmd_valid_o) |-> $past(armed_o, 3))
    else $error("flash operation while unarmed");
  AST_RD_PULSE: assert property (rd_req_o |-> armed_o ##1 !rd_req_o [*3])
    else $error("read request not a lone pulse");
  // Protection bits only fall, or all rise on erase
  AST_LOCK_AND: assert property ($changed(lock_bits_o) |->
    ((lock_bits_o & ~$past(lock_bits_o)) == 8'h00) || (lock_bits_o == 8'hFF))
    else $error("lock bits rose without erase");
  // Operation held until taken
  AST_CMD_HOLD: assert property (fl_cmd_valid_o && !fl_cmd_ready_i |=>
    fl_cmd_valid_o && $stable(fl_cmd_o))
    else $error("flash operation dropped before taken");
  AST_OVR_FULL: assert property ($rose(overrun_o) |-> fl_cmd_valid_o)
    else $error("overrun without a waiting queue");
  // Serial output moves only while the clock is low
  AST_SO_FALL: assert property ($changed(so_o) |-> !sck_i && !$past(sck_i, 2))
    else $error("serial output changed outside low phase");
endmodule : programming_select_pin_port_chk

bind flash_programming_select_pin_port programming_select_pin_port_chk u_chk (
  .clk_i, .srst_i, .sck_i, .programming_select_pin_n_i, .so_o, .so_oe_o, .armed_o,
  .flash_timing_value_o, .lock_bits_o, .overrun_o, .fl_cmd_valid_o, .fl_cmd_o,
  .fl_cmd_ready_i, .rd_req_o
);

// >>> tb/flash_macro_model.sv
// Behavioural flash macro: page buffer, array, busy timing and byte reads.
// Assumes the port's fl_* and rd_* handshakes in the clk_i domain.
`timescale 1ns/1ps
module flash_macro_model #(
  parameter int BUSY_CYCLES = 2500
) (
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     stall_i,
  input  wire logic                     cmd_valid_i,
  input  wire flash_programming_select_pin_pkg::fl_cmd_t  cmd_i,
  output logic                          cmd_ready_o,
  output logic                          busy_o,
  input  wire logic                     rd_req_i,
  input  wire flash_programming_select_pin_pkg::fl_addr_t rd_addr_i,
  output logic [7:0]                    rd_data_o,
  output logic                          rd_valid_o
);
  import flash_programming_select_pin_pkg::*;
  logic [7:0] mem_q [0:32767];
  logic [7:0] page_q [0:127];
  logic [1:0] rd_pipe_q = 2'h0;
  int         busy_q = 0;
  int         n_ops = 0;

  // Slow side: refuses while stalled or busy
  assign cmd_ready_o = !stall_i && (busy_q == 0);
  assign busy_o      = (busy_q != 0);

  initial
  begin
    foreach (mem_q[i]) mem_q[i] = 8'hFF;
    foreach (page_q[i]) page_q[i] = 8'hFF;
  end

  // Reads answer three cycles late; the idle line toggles between the last byte and its inverse
  always @(posedge clk_i)
  begin
    rd_pipe_q  <= srst_i ? 2'h0 : {rd_pipe_q[0], rd_req_i};
    rd_valid_o <= rd_pipe_q[1] && !srst_i;
    rd_data_o  <= srst_i ? 8'h00 : (rd_pipe_q[1] ? mem_q[rd_addr_i] : ~rd_data_o);
  end

  // Operations: erase, buffer load, page program
  always @(posedge clk_i)
  begin
    if (srst_i)
      busy_q <= 0;
    else if (busy_q != 0)
      busy_q <= busy_q - 1;
    else if (cmd_valid_i && cmd_ready_o)
    begin
      n_ops <= n_ops + 1;
      case (cmd_i.op)
        FL_ERASE:
        begin
          foreach (mem_q[i]) mem_q[i] <= 8'hFF;
          busy_q <= BUSY_CYCLES / 4;
        end
        FL_LOAD: page_q[cmd_i.addr.offset] <= cmd_i.data;
        default:
        begin
          foreach (page_q[i]) mem_q[{cmd_i.addr.page, 7'(i)}] <= page_q[i];
          busy_q <= BUSY_CYCLES;
        end
      endcase
    end
  end
endmodule : flash_macro_model

// >>> tb/testbench.sv
// Self-checking bench of the serial flash programming port with a flash macro model.
// Assumes the package, port, FIFO, checker and model are compiled first.
`timescale 1ns/1ps
module testbench;
  import flash_programming_select_pin_pkg::*;
  localparam logic [47:0] SIG = 48'hA1B2_C3D4_E5F6;  // Arbitrary identity value
  localparam logic [5:0]  TIM_MIN = 6'h05;  // Smallest legal timing value for the modelled crystal

  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        sck_i = 1'b0;
  logic        si_i = 1'b0;
  logic        sel_n = 1'b1;
  logic        stall = 1'b0;
  logic        so_o, so_oe_o, armed_o, overrun_o, cmd_valid, cmd_ready, busy, rd_req, rd_valid;
  logic [5:0]  timing;
  logic [7:0]  lock, rd_data;
  fl_cmd_t     cmd;
  fl_addr_t    rd_addr;
  logic [15:0] rx;
  logic [6:0]  offs [8];
  logic [7:0]  data [8];
  int          num_errors = 0;
  int          comparisons = 0;

  initial forever #2 clk_i = ~clk_i;

  flash_programming_select_pin_port #(.FIFO_DEPTH(16), .SIG_BYTES(SIG)) u_dut (
    .clk_i, .srst_i, .sck_i, .si_i, .programming_select_pin_n_i(sel_n),
    .so_o, .so_oe_o, .armed_o, .flash_timing_value_o(timing), .lock_bits_o(lock),
    .overrun_o, .fl_cmd_valid_o(cmd_valid), .fl_cmd_o(cmd), .fl_cmd_ready_i(cmd_ready),
    .fl_busy_i(busy), .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid)
  );

  flash_macro_model u_flash (
    .clk_i, .srst_i, .stall_i(stall), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
    .cmd_ready_o(cmd_ready), .busy_o(busy), .rd_req_i(rd_req), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid)
  );

  // Expected signature byte; indices six and above read as zero
  function automatic logic [7:0] sig_exp(input int s);
    return (s < 6) ? SIG[47 - 8 * s -: 8] : 8'h00;
  endfunction : sig_exp

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string what);
    chk8({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // One instruction MSB first; rx keeps the answer of bytes three and four
  task automatic xfer(input logic [31:0] w, input bit rd);
    for (int i = 31; i >= 0; i--)
    begin
      si_i <= w[i];
      #62.5;
      if (rd && i == 7)
        #250;  // Gap before byte four of reads
      rx = {rx[14:0], so_o};
      sck_i <= 1'b1;
      #62.5;
      sck_i <= 1'b0;
    end
  endtask : xfer

  task automatic pulse();
    #62.5 sck_i <= 1'b1;
    #62.5 sck_i <= 1'b0;
  endtask : pulse

  task automatic rd_mem(input logic [7:0] p, input logic [6:0] o);
    xfer({4'h2, o[0], 3'h0, p, o[6:1], 2'h0, 8'h00}, 1'b1);
  endtask : rd_mem

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (8) @(posedge clk_i);
    while ((cmd_valid || busy) && n < 20000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk1(n < 20000, 1'b1, "flash idle wait");
    if (n == 20000)
      stop_test();
  endtask : wait_idle

  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic [7:0]  p, v1, v2;
    int          base;
    void'($urandom(32'h3E8AA68C));
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1.3;
    chk8(lock, 8'hFF, "lock reset");
    chk8({2'h0, timing}, 8'h00, "timing reset");
    chk1(so_oe_o, 1'b0, "oe deselected");
    @(posedge clk_i);
    sel_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk1(so_oe_o, 1'b1, "oe selected");
    xfer(32'hACE0_0000, 1'b0);
    repeat (20) @(posedge clk_i);
    chk8(rx[15:8], 8'h00, "unsynced echo");
    chk8(lock, 8'hFF, "lock while unarmed");
    chk1(armed_o, 1'b0, "unarmed");
    repeat (3) pulse();
    for (int k = 0; k < 32 && rx[15:8] !== 8'h53; k++)
    begin
      if (k > 0)
        pulse();
      xfer(32'hAC53_0000, 1'b0);
    end
    chk8(rx[15:8], 8'h53, "enable echo");
    chk1(armed_o, 1'b1, "armed");
    base = u_flash.n_ops;
    xfer(32'h10FF_FFFF, 1'b0);
    r = $urandom;
    xfer({16'hAC5D, r[15:0]}, 1'b0);
    repeat (20) @(posedge clk_i);
    chk8({2'h0, timing}, {2'h0, r[5:0]}, "timing value");
    chk8(8'(u_flash.n_ops - base), 8'h00, "ops from unknown");
    xfer({16'hAC5D, 10'h000, TIM_MIN}, 1'b0);
    repeat (20) @(posedge clk_i);
    chk8({2'h0, timing}, {2'h0, TIM_MIN}, "legal timing value");
    xfer({8'hAC, 3'h4, r[20:16], 16'h0000}, 1'b0);
    wait_idle();
    rd_mem(r[31:24], r[30:24]);
    chk8(rx[7:0], 8'hFF, "erased byte");
    p = 8'($urandom);
    for (int i = 0; i < 8; i++)
    begin
      offs[i] = 7'(i * 16 + (i == 7 ? 15 : $urandom_range(15)));
      data[i] = 8'($urandom) & 8'hFE;  // Never 0xFF, so polling can tell
      xfer({4'h4, offs[i][0], 3'h0, 8'($urandom), offs[i][6:1], 2'h0, data[i]}, 1'b0);
    end
    xfer({8'h4C, p, 16'h0000}, 1'b0);
    rd_mem(p, offs[0]);
    chk8(rx[7:0], 8'hFF, "read while writing");
    for (int k = 0; k < 10 && rx[7:0] === 8'hFF; k++)
      rd_mem(p, offs[0]);
    for (int i = 0; i < 8; i++)
    begin
      if (i > 0)
        rd_mem(p, offs[i]);
      chk8(rx[7:0], data[i], "read back");
    end
    v1 = 8'($urandom);
    v2 = 8'($urandom) & 8'hFE;  // Clears the read enable bit
    xfer({8'hAC, 3'h7, r[4:0], 8'h00, v1}, 1'b0);
    xfer({8'hAC, 3'h7, r[9:5], 8'h00, v2}, 1'b0);
    xfer(32'h5800_0000, 1'b1);
    chk8(rx[7:0], v1 & v2, "lock read");
    chk8(lock, v1 & v2, "lock bits");
    rd_mem(p, offs[1]);
    chk8(rx[7:0], 8'h00, "read while locked");
    for (int s = 0; s < 8; s++)
    begin
      xfer({8'h30, r[7:0], 5'h00, 3'(s), 8'h00}, 1'b1);
      chk8(rx[7:0], sig_exp(s), "signature");
    end
    xfer({8'hAC, 8'h9F, 16'hFFFF}, 1'b0);
    wait_idle();
    chk8(lock, 8'hFF, "lock after erase");
    @(posedge clk_i);
    stall <= 1'b1;
    base = u_flash.n_ops;
    for (int i = 0; i < 20; i++)
      xfer({8'h48, 8'h00, 8'($urandom), 8'($urandom)}, 1'b0);
    chk1(overrun_o, 1'b1, "queue overrun");
    @(posedge clk_i);
    stall <= 1'b0;
    wait_idle();
    chk1((u_flash.n_ops - base) inside {[16:19]}, 1'b1, "queued loads");
    @(posedge clk_i);
    sel_n <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk1(armed_o, 1'b0, "disarmed");
    chk1(so_oe_o, 1'b0, "oe off");
    chk1(overrun_o, 1'b0, "overrun cleared");
    stop_test();
  end

  // Run time limit
  initial
  begin
    #400000;
    chk1(1'b0, 1'b1, "run time limit");
    stop_test();
  end
endmodule : testbench
